// ### dv/i2ctw_bus_model.sv
`timescale 1ns/10ps
// ==========================================================
// Open-drain bus with pull-ups; other parties pull through *_pull.
module i2ctw_bus_model (
	input  wire logic scl_oe,
	input  wire logic sda_oe,
	input  wire logic scl_pull,
	input  wire logic sda_pull,
	output logic      scl,
	output logic      sda
);
	assign scl = !(scl_oe || scl_pull);
	assign sda = !(sda_oe || sda_pull);
endmodule

// ### dv/i2ctw_props.sv
`timescale 1ns/10ps
// ==========================================================
// Link-side checks, all sampled on the oscillator clock.
module i2ctw_props #(
	parameter int unsigned WDOG_SLOW_CYC = 2000
) (
	input wire logic osc_clk,
	input wire logic presetn,
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic ctl_scl_en,
	input wire logic remote_active,
	input wire logic scl_clean,
	input wire logic sda_clean,
	input wire logic bus_free
);
	logic [3:0] pulses_q;
	logic [7:0] quiet_q;

	default clocking @(posedge osc_clk); endclocking
	default disable iff (!presetn);

	// A burst is only closed after a long quiet gap, so short SCL
	// high phases never split one recovery burst into two.
	always_ff @(posedge osc_clk or negedge presetn) begin
		if (!presetn) begin
			quiet_q  <= 8'h00;
			pulses_q <= 4'h0;
		end else begin
			if (scl_oe || ctl_scl_en) begin
				quiet_q <= 8'h00;
			end else if (quiet_q != 8'hff) begin
				quiet_q <= quiet_q + 8'h01;
			end
			if (quiet_q == 8'hff) begin
				pulses_q <= 4'h0;
			end else if ($rose(scl_oe) && !ctl_scl_en && !remote_active) begin
				pulses_q <= pulses_q + 4'h1;
			end
		end
	end

	property p_open_drain;
		!scl_o && !sda_o;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("pin driven high");
	property p_remote_clr;
		!remote_active && !$past(remote_active) |-> !sda_oe;
	endproperty
	a_remote_clr: assert property (p_remote_clr)
		else $error("sda driven without remote access");
	property p_sda_delay;
		$changed(sda_oe) && remote_active && $past(remote_active)
			|-> !$past(scl_clean) && !$past(scl_clean, 5);
	endproperty
	a_sda_delay: assert property (p_sda_delay)
		else $error("sda changed too soon after scl fall");
	property p_free_rise;
		$rose(bus_free) |-> sda_clean && scl_clean;
	endproperty
	a_free_rise: assert property (p_free_rise)
		else $error("bus free with a line low");
	property p_recover_cnt;
		pulses_q <= 4'h9;
	endproperty
	a_recover_cnt: assert property (p_recover_cnt)
		else $error("too many recovery pulses");
	property p_low_min;
		$rose(scl_oe) && !remote_active |-> scl_oe [*4];
	endproperty
	a_low_min: assert property (p_low_min)
		else $error("scl low phase too short");
	property p_high_min;
		$fell(scl_oe) && !remote_active |-> !scl_oe [*4];
	endproperty
	a_high_min: assert property (p_high_min)
		else $error("scl high phase too short");
	property p_filter;
		$stable(scl_i) [*8] |-> scl_clean == scl_i;
	endproperty
	a_filter: assert property (p_filter)
		else $error("steady scl not passed");
endmodule

bind i2ctw_top i2ctw_props #(.WDOG_SLOW_CYC(WDOG_SLOW_CYC)) u_i2ctw_props (.*);

// ### dv/tb.sv
`timescale 1ns/10ps
module tb;
	localparam int unsigned SLOW = 2000;
	typedef struct packed {
		logic w; logic [11:0] a; logic [7:0] d; logic [7:0] e; logic r;
	} i2ctw_row_t;
	logic        pclk, osc_clk, presetn, psel, penable, pwrite, pready;
	logic        pslverr, scl_i, sda_i, scl_o, sda_o, scl_oe, sda_oe, se;
	logic        ctl_scl_en, remote_active, remote_ack_cycle, remote_sda_val;
	logic        scl_clean, sda_clean, bus_free, p;
	logic [1:0]  pl;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int          failures, comparisons, n, t0, t1, cyc;
	int          lim [3] = '{SLOW, i2ctw_pkg::WDOG_FAST_CYC, 3000};
	i2ctw_row_t  rows [12] = '{
		'{1'b0, i2ctw_pkg::ADDR_HOLD_FILT, 8'h00, 8'h1c, 1'b0},
		'{1'b0, i2ctw_pkg::ADDR_CTRL2, 8'h00, 8'h10, 1'b0},
		'{1'b0, i2ctw_pkg::ADDR_SCL_HIGH, 8'h00, 8'h7a, 1'b0},
		'{1'b0, i2ctw_pkg::ADDR_SCL_LOW, 8'h00, 8'h7a, 1'b0},
		'{1'b1, i2ctw_pkg::ADDR_HOLD_FILT, 8'h3c, 8'h00, 1'b0},
		'{1'b0, i2ctw_pkg::ADDR_HOLD_FILT, 8'h00, 8'h3c, 1'b0},
		'{1'b1, i2ctw_pkg::ADDR_SCL_HIGH, 8'h02, 8'h00, 1'b0},
		'{1'b0, i2ctw_pkg::ADDR_SCL_HIGH, 8'h00, 8'h02, 1'b0},
		'{1'b1, i2ctw_pkg::ADDR_SCL_LOW, 8'h00, 8'h00, 1'b0},
		'{1'b0, i2ctw_pkg::ADDR_SCL_LOW, 8'h00, 8'h00, 1'b0},
		'{1'b1, 12'hffc, 8'hff, 8'h00, 1'b1},
		'{1'b0, 12'hffc, 8'h00, 8'h00, 1'b1}};

	i2ctw_top #(.WDOG_SLOW_CYC(SLOW)) u_i2ctw_top (.*);
	i2ctw_bus_model u_i2ctw_bus_model (.scl_oe, .sda_oe,
		.scl_pull(pl[1]), .sda_pull(pl[0]), .scl(scl_i), .sda(sda_i));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		osc_clk = 1'b0;
		#3;
		forever #16 osc_clk = ~osc_clk;
	end

	task automatic end_sim();
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Any unknown in g makes the range test unknown and so fail.
	task automatic chk(input logic [32:0] g, input logic [32:0] lo,
		input logic [32:0] hi);
		comparisons++;
		if ((g >= lo && g <= hi) !== 1'b1) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, g, lo);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		se = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		repeat (12) @(posedge osc_clk);
	endtask

	task automatic wfor(ref logic s, input logic v, output int t);
		t = 0;
		while (s !== v && t < 3000) begin
			@(posedge osc_clk);
			t++;
		end
	endtask

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			failures++;
			end_sim();
		end
	end

	initial begin
		{psel, penable, pwrite, presetn, ctl_scl_en, pl} = '0;
		{remote_active, remote_ack_cycle, remote_sda_val} = '0;
		{paddr, pwdata, cyc, failures, comparisons} = '0;
		repeat (10) @(posedge pclk);
		chk({scl_oe, sda_oe, bus_free, scl_clean, sda_clean}, 5'h03, 5'h03);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge osc_clk);
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, {24'h0, rows[i].d});
			if (rows[i].w) begin
				chk(33'(se), 33'(rows[i].r), 33'(rows[i].r));
			end else begin
				chk({se, rd}, {rows[i].r, 24'h0, rows[i].e},
					{rows[i].r, 24'h0, rows[i].e});
			end
		end
		@(posedge osc_clk);
		pl <= 2'b11;
		wfor(scl_clean, 1'b0, t0);
		wfor(sda_clean, 1'b0, t1);
		chk(33'(t1), 33'd4, 33'd5);
		pl <= 2'b00;
		for (int i = 0; i < 4; i++) begin
			repeat (20) @(posedge osc_clk);
			pl <= 2'b10 >> i[0];
			repeat (i < 2 ? 1 : 3) @(posedge osc_clk);
			pl <= 2'b00;
			n = 0;
			repeat (20) begin
				@(posedge osc_clk);
				n += int'(!(scl_clean && sda_clean));
			end
			chk(33'(n > 0), 33'(i >= 2), 33'(i >= 2));
		end
		for (int k = 0; k < 3; k++) begin
			wr(i2ctw_pkg::ADDR_CTRL2, 32'h10 + 32'(k + (k > 0)));
			pl <= 2'b11;
			repeat (8) @(posedge osc_clk);
			pl <= 2'b00;
			wfor(bus_free, 1'b1, t0);
			chk(33'(t0), 33'(lim[k]), 33'(lim[k] + 25));
			apb(1'b0, i2ctw_pkg::ADDR_STATUS, 32'h0);
			chk(33'(rd), 33'(k < 2), 33'(k < 2));
		end
		ctl_scl_en <= 1'b1;
		wfor(scl_oe, 1'b1, t0);
		wfor(scl_oe, 1'b0, t0);
		wfor(scl_oe, 1'b1, t1);
		// Stop only at the end of a low phase, so no phase is cut short.
		wfor(scl_oe, 1'b0, n);
		ctl_scl_en <= 1'b0;
		chk(33'(n), 33'd4, 33'd4);
		chk(33'(t0), 33'd4, 33'd4);
		chk(33'(t1), 33'd6, 33'd6);
		wr(i2ctw_pkg::ADDR_CTRL2, 32'h12);
		pl <= 2'b01;
		{n, p} = '0;
		repeat (1600) begin
			@(posedge osc_clk);
			n += int'(scl_oe && !p);
			p = scl_oe;
		end
		chk({n[31:0], bus_free}, 33'd18, 33'd18);
		pl <= 2'b00;
		for (int s = 0; s < 5; s++) begin
			wr(i2ctw_pkg::ADDR_CTRL2, 32'h11 + 32'((s % 4) << 2));
			remote_active    <= 1'b1;
			remote_ack_cycle <= (s == 4);
			pl               <= 2'b10;
			wfor(scl_clean, 1'b0, t0);
			wfor(sda_oe, 1'b1, t0);
			chk(33'(t0), 33'(i2ctw_pkg::DELAY_BASE_CYC + s % 4),
				33'(i2ctw_pkg::DELAY_BASE_CYC + 1 + s % 4));
			pl <= 2'b00;
			wfor(scl_i, 1'b1, t1);
			n = s < 4 ? 0
				: i2ctw_pkg::SETUP_BASE_CYC + i2ctw_pkg::SETUP_STEP_CYC;
			chk(33'(t1), 33'(n > 0 ? n - 2 : 0), 33'(n + 2));
			remote_active    <= 1'b0;
			remote_ack_cycle <= 1'b0;
			repeat (4) @(posedge osc_clk);
			chk(33'(sda_oe), 33'd0, 33'd0);
		end
		end_sim();
	end
endmodule

// ### rtl/i2ctw_filt_if.sv
`timescale 1ns/10ps
interface i2ctw_filt_if;
	logic       raw;
	logic [3:0] thresh;
	logic       clean;
	modport filt (input raw, input thresh, output clean);
	modport user (output raw, output thresh, input clean);
endinterface

// ### rtl/i2ctw_glitch_filter.sv
`timescale 1ns/10ps
module i2ctw_glitch_filter (
	input  wire logic     clk,
	input  wire logic     rst_n,
	i2ctw_filt_if.filt    f
);
	logic [3:0] cnt_q;
	logic       clean_q;

	assign f.clean = clean_q;

	// ==========================================================
	// A level must hold thresh+1 cycles before it is believed.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q   <= 4'h0;
			clean_q <= 1'b1;
		end else if (f.raw == clean_q) begin
			cnt_q <= 4'h0;
		end else if (cnt_q >= f.thresh) begin
			clean_q <= f.raw;
			cnt_q   <= 4'h0;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule

// ### rtl/i2ctw_pkg.sv
package i2ctw_pkg;

	// ==========================================================
	// Register indices; the byte address is four times the index.
	localparam logic [7:0]  IDX_HOLD_FILT  = 8'h08;
	localparam logic [7:0]  IDX_CTRL2      = 8'h09;
	localparam logic [7:0]  IDX_SCL_HIGH   = 8'h0a;
	localparam logic [7:0]  IDX_SCL_LOW    = 8'h0b;
	localparam logic [7:0]  IDX_STATUS     = 8'h10;
	localparam logic [11:0] ADDR_HOLD_FILT = {2'b00, IDX_HOLD_FILT, 2'b00};
	localparam logic [11:0] ADDR_CTRL2     = {2'b00, IDX_CTRL2, 2'b00};
	localparam logic [11:0] ADDR_SCL_HIGH  = {2'b00, IDX_SCL_HIGH, 2'b00};
	localparam logic [11:0] ADDR_SCL_LOW   = {2'b00, IDX_SCL_LOW, 2'b00};
	localparam logic [11:0] ADDR_STATUS    = {2'b00, IDX_STATUS, 2'b00};

	// ==========================================================
	// Field positions.
	localparam int unsigned HOLD_MSB  = 6;
	localparam int unsigned HOLD_LSB  = 4;
	localparam int unsigned FILT_MSB  = 3;
	localparam int unsigned FILT_LSB  = 0;
	localparam int unsigned SETUP_MSB = 7;
	localparam int unsigned SETUP_LSB = 4;
	localparam int unsigned DELAY_MSB = 3;
	localparam int unsigned DELAY_LSB = 2;
	localparam int unsigned FAST_BIT  = 1;
	localparam int unsigned DIS_BIT   = 0;
	localparam int unsigned ST_FREE   = 0;
	localparam int unsigned ST_CLEAR  = 1;

	// ==========================================================
	// Reset values.
	localparam logic [7:0] RST_HOLD_FILT = 8'h1c;
	localparam logic [7:0] RST_CTRL2     = 8'h10;
	localparam logic [7:0] RST_SCL_HIGH  = 8'h7a;
	localparam logic [7:0] RST_SCL_LOW   = 8'h7a;

	// ==========================================================
	// Timing, in the oscillator domain.
	localparam int unsigned OSC_PERIOD_NS  = 40;
	localparam int unsigned HOLD_STEP_NS   = 50;
	localparam int unsigned FILT_STEP_NS   = 5;
	localparam int unsigned SETUP_BASE_NS  = 80;
	localparam int unsigned SETUP_STEP_NS  = 640;
	localparam int unsigned DELAY_BASE_NS  = 240;
	localparam int unsigned DELAY_STEP_NS  = 40;
	localparam int unsigned SCL_EXTRA_CYC  = 4;
	localparam int unsigned RECOVER_PULSES = 9;
	localparam int unsigned WDOG_FAST_US   = 50;
	localparam int unsigned WDOG_SLOW_S    = 1;
	localparam int unsigned SETUP_BASE_CYC = SETUP_BASE_NS / OSC_PERIOD_NS;
	localparam int unsigned SETUP_STEP_CYC = SETUP_STEP_NS / OSC_PERIOD_NS;
	localparam int unsigned DELAY_BASE_CYC = DELAY_BASE_NS / OSC_PERIOD_NS;
	localparam int unsigned DELAY_STEP_CYC = DELAY_STEP_NS / OSC_PERIOD_NS;
	localparam int unsigned WDOG_FAST_CYC  =
		WDOG_FAST_US * 1000 / OSC_PERIOD_NS;
	localparam int unsigned WDOG_SLOW_CYC  =
		WDOG_SLOW_S * 1000000000 / OSC_PERIOD_NS;

	typedef enum logic [1:0] {
		WD_IDLE  = 2'b00,
		WD_FREE  = 2'b01,
		WD_CLEAR = 2'b10
	} i2ctw_wd_state_t;

endpackage

// ### rtl/i2ctw_top.sv
`timescale 1ns/10ps
// Functional notes
// - SDA input delayed by hold, 50 ns steps.
// - Reject SCL/SDA glitches up to depth times 5ns.
// - ACK setup 80 ns plus 640 ns steps.
// - SDA changes 240 to 360 ns after SCL fall.
// - Watchdog 50 us when fast, else one second.
// - Disable bit stops the bus watchdog.
// - Idle bus with SDA high is free.
// - Idle bus with SDA low gets nine clocks.
// - SCL high is 40 ns times (field+4).
// - SCL low is 40 ns times (field+4).
module i2ctw_top #(
	parameter int unsigned WDOG_SLOW_CYC = i2ctw_pkg::WDOG_SLOW_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        osc_clk,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	input  wire logic        ctl_scl_en,
	input  wire logic        remote_active,
	input  wire logic        remote_ack_cycle,
	input  wire logic        remote_sda_val,
	output logic             scl_clean,
	output logic             sda_clean,
	output logic             bus_free
);
	localparam int unsigned WD_W = $clog2(WDOG_SLOW_CYC + 1);

	// ==========================================================
	// APB register file.
	logic [7:0]  hold_filt_q;
	logic [7:0]  ctrl2_q;
	logic [7:0]  scl_high_q;
	logic [7:0]  scl_low_q;
	logic [31:0] prdata_q;
	logic [1:0]  st_free_s_q;
	logic [1:0]  st_clear_s_q;
	logic        hit;
	logic        wr_en;
	logic [7:0]  rd_byte;
	logic        wd_clear;

	always_comb begin
		hit     = 1'b1;
		rd_byte = 8'h00;
		case (paddr)
			i2ctw_pkg::ADDR_HOLD_FILT: rd_byte = hold_filt_q;
			i2ctw_pkg::ADDR_CTRL2:     rd_byte = ctrl2_q;
			i2ctw_pkg::ADDR_SCL_HIGH:  rd_byte = scl_high_q;
			i2ctw_pkg::ADDR_SCL_LOW:   rd_byte = scl_low_q;
			i2ctw_pkg::ADDR_STATUS:
				rd_byte = {6'h00, st_clear_s_q[1], st_free_s_q[1]};
			default:                   hit = 1'b0;
		endcase
	end

	// Zero wait states: read data are latched in the setup cycle.
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign prdata  = prdata_q;
	assign wr_en   = psel & penable & pwrite & hit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_q <= {24'h00_0000, rd_byte};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_filt_q <= i2ctw_pkg::RST_HOLD_FILT;
			ctrl2_q     <= i2ctw_pkg::RST_CTRL2;
			scl_high_q  <= i2ctw_pkg::RST_SCL_HIGH;
			scl_low_q   <= i2ctw_pkg::RST_SCL_LOW;
		end else if (wr_en) begin
			case (paddr)
				i2ctw_pkg::ADDR_HOLD_FILT: hold_filt_q <= pwdata[7:0];
				i2ctw_pkg::ADDR_CTRL2:     ctrl2_q     <= pwdata[7:0];
				i2ctw_pkg::ADDR_SCL_HIGH:  scl_high_q  <= pwdata[7:0];
				i2ctw_pkg::ADDR_SCL_LOW:   scl_low_q   <= pwdata[7:0];
				default:                   ;
			endcase
		end
	end

	// ==========================================================
	// Configuration crossing: a toggle handshake carries a shadow
	// word that stays frozen until the oscillator side has taken it.
	logic [31:0] cfg_word;
	logic [31:0] shadow_q;
	logic        req_q;
	logic [1:0]  ack_s_q;
	logic [2:0]  req_s_q;
	logic        lack_q;
	logic [31:0] lcfg_q;
	logic [1:0]  lrst_q;
	logic        lrst_n;

	assign cfg_word = {scl_low_q, scl_high_q, ctrl2_q, hold_filt_q};
	assign lrst_n   = lrst_q[1];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shadow_q <= {i2ctw_pkg::RST_SCL_LOW, i2ctw_pkg::RST_SCL_HIGH,
				i2ctw_pkg::RST_CTRL2, i2ctw_pkg::RST_HOLD_FILT};
			req_q    <= 1'b0;
		end else if (req_q == ack_s_q[1] && shadow_q != cfg_word) begin
			shadow_q <= cfg_word;
			req_q    <= ~req_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_s_q      <= 2'b00;
			st_free_s_q  <= 2'b00;
			st_clear_s_q <= 2'b00;
		end else begin
			ack_s_q      <= {ack_s_q[0], lack_q};
			st_free_s_q  <= {st_free_s_q[0], bus_free};
			st_clear_s_q <= {st_clear_s_q[0], wd_clear};
		end
	end

	// The link reset asserts at once and releases on the oscillator.
	always_ff @(posedge osc_clk or negedge presetn) begin
		if (!presetn) begin
			lrst_q <= 2'b00;
		end else begin
			lrst_q <= {lrst_q[0], 1'b1};
		end
	end

	always_ff @(posedge osc_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			req_s_q <= 3'b000;
			lack_q  <= 1'b0;
			lcfg_q  <= {i2ctw_pkg::RST_SCL_LOW, i2ctw_pkg::RST_SCL_HIGH,
				i2ctw_pkg::RST_CTRL2, i2ctw_pkg::RST_HOLD_FILT};
		end else begin
			req_s_q <= {req_s_q[1:0], req_q};
			lack_q  <= req_s_q[2];
			if (req_s_q[2] != req_s_q[1]) begin
				lcfg_q <= shadow_q;
			end
		end
	end

	// ==========================================================
	// Input conditioning on the oscillator clock.
	logic [3:0]  l_hold;
	logic [3:0]  l_filt;
	logic [3:0]  l_setup;
	logic [1:0]  l_delay;
	logic [7:0]  l_high;
	logic [7:0]  l_low;
	logic [3:0]  filt_cyc;
	logic [3:0]  hold_cyc;
	logic [1:0]  scl_sync_q;
	logic [1:0]  sda_sync_q;
	logic [15:0] sda_dly_q;
	logic        sda_tap;
	logic        scl_clean_q;
	logic        sda_clean_q;
	logic        scl_prev_q;
	logic        sda_prev_q;
	logic        scl_fall;

	assign l_hold  = {1'b0, lcfg_q[i2ctw_pkg::HOLD_MSB:i2ctw_pkg::HOLD_LSB]};
	assign l_filt  = lcfg_q[i2ctw_pkg::FILT_MSB:i2ctw_pkg::FILT_LSB];
	assign l_setup = lcfg_q[8 + i2ctw_pkg::SETUP_MSB:
		8 + i2ctw_pkg::SETUP_LSB];
	assign l_delay = lcfg_q[8 + i2ctw_pkg::DELAY_MSB:
		8 + i2ctw_pkg::DELAY_LSB];
	assign l_high  = lcfg_q[23:16];
	assign l_low   = lcfg_q[31:24];

	// Longest rejected glitch rounds down; the hold rounds up.
	assign filt_cyc = 4'((32'(l_filt) * i2ctw_pkg::FILT_STEP_NS)
		/ i2ctw_pkg::OSC_PERIOD_NS);
	assign hold_cyc = 4'((32'(l_hold) * i2ctw_pkg::HOLD_STEP_NS
		+ i2ctw_pkg::OSC_PERIOD_NS - 1) / i2ctw_pkg::OSC_PERIOD_NS);

	always_ff @(posedge osc_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			scl_sync_q <= 2'b11;
			sda_sync_q <= 2'b11;
		end else begin
			scl_sync_q <= {scl_sync_q[0], scl_i};
			sda_sync_q <= {sda_sync_q[0], sda_i};
		end
	end

	i2ctw_filt_if scl_f ();
	i2ctw_filt_if sda_f ();
	assign scl_f.raw    = scl_sync_q[1];
	assign scl_f.thresh = filt_cyc;
	assign sda_f.raw    = sda_sync_q[1];
	assign sda_f.thresh = filt_cyc;

	i2ctw_glitch_filter u_scl_filt (
		.clk   (osc_clk),
		.rst_n (lrst_n),
		.f     (scl_f)
	);

	i2ctw_glitch_filter u_sda_filt (
		.clk   (osc_clk),
		.rst_n (lrst_n),
		.f     (sda_f)
	);

	assign sda_tap = (hold_cyc == 4'h0) ? sda_f.clean
		: sda_dly_q[hold_cyc - 4'h1];

	always_ff @(posedge osc_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			sda_dly_q   <= 16'hffff;
			scl_clean_q <= 1'b1;
			sda_clean_q <= 1'b1;
			scl_prev_q  <= 1'b1;
			sda_prev_q  <= 1'b1;
		end else begin
			sda_dly_q   <= {sda_dly_q[14:0], sda_f.clean};
			scl_clean_q <= scl_f.clean;
			sda_clean_q <= sda_tap;
			scl_prev_q  <= scl_clean_q;
			sda_prev_q  <= sda_clean_q;
		end
	end

	assign scl_clean = scl_clean_q;
	assign sda_clean = sda_clean_q;
	assign scl_fall  = scl_prev_q & ~scl_clean_q;

	// ==========================================================
	// SCL generator, shared by controller use and bus recovery.
	// Clock stretching by other targets is not honoured here.
	i2ctw_pkg::i2ctw_wd_state_t wd_state_q;
	logic       gen_run;
	logic       gen_low_q;
	logic [8:0] gen_cnt_q;
	logic [8:0] gen_last;
	logic       gen_term;

	assign wd_clear = (wd_state_q == i2ctw_pkg::WD_CLEAR);
	assign gen_run  = ctl_scl_en | wd_clear;
	assign gen_last = (gen_low_q ? {1'b0, l_low} : {1'b0, l_high})
		+ 9'(i2ctw_pkg::SCL_EXTRA_CYC - 1);
	assign gen_term = (gen_cnt_q == gen_last);

	always_ff @(posedge osc_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			gen_low_q <= 1'b0;
			gen_cnt_q <= 9'h000;
		end else if (!gen_run) begin
			gen_low_q <= 1'b0;
			gen_cnt_q <= 9'h000;
		end else if (gen_term) begin
			gen_low_q <= ~gen_low_q;
			gen_cnt_q <= 9'h000;
		end else begin
			gen_cnt_q <= gen_cnt_q + 9'h001;
		end
	end

	// ==========================================================
	// Bus watchdog.
	logic [WD_W-1:0] wd_cnt_q;
	logic [WD_W-1:0] wd_limit;
	logic [3:0]      pulse_cnt_q;
	logic            activity;
	logic            wd_off;

	assign wd_off   = lcfg_q[8 + i2ctw_pkg::DIS_BIT];
	assign wd_limit = lcfg_q[8 + i2ctw_pkg::FAST_BIT]
		? WD_W'(i2ctw_pkg::WDOG_FAST_CYC - 1)
		: WD_W'(WDOG_SLOW_CYC - 1);
	assign activity = (scl_clean_q != scl_prev_q)
		| (sda_clean_q != sda_prev_q) | ctl_scl_en;
	assign bus_free = (wd_state_q == i2ctw_pkg::WD_FREE);

	always_ff @(posedge osc_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			wd_cnt_q <= '0;
		end else if (wd_off || activity
			|| wd_state_q != i2ctw_pkg::WD_IDLE) begin
			wd_cnt_q <= '0;
		end else if (wd_cnt_q != wd_limit) begin
			wd_cnt_q <= wd_cnt_q + WD_W'(1);
		end
	end

	always_ff @(posedge osc_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			wd_state_q  <= i2ctw_pkg::WD_IDLE;
			pulse_cnt_q <= 4'h0;
		end else if (wd_off) begin
			wd_state_q  <= i2ctw_pkg::WD_IDLE;
			pulse_cnt_q <= 4'h0;
		end else begin
			case (wd_state_q)
				i2ctw_pkg::WD_IDLE: begin
					pulse_cnt_q <= 4'h0;
					if (!activity && wd_cnt_q == wd_limit) begin
						wd_state_q <= sda_clean_q ? i2ctw_pkg::WD_FREE
							: i2ctw_pkg::WD_CLEAR;
					end
				end
				i2ctw_pkg::WD_FREE: begin
					if (activity) begin
						wd_state_q <= i2ctw_pkg::WD_IDLE;
					end
				end
				i2ctw_pkg::WD_CLEAR: begin
					if (gen_low_q && gen_term) begin
						pulse_cnt_q <= pulse_cnt_q + 4'h1;
						if (pulse_cnt_q ==
							4'(i2ctw_pkg::RECOVER_PULSES - 1)) begin
							wd_state_q <= i2ctw_pkg::WD_IDLE;
						end
					end
				end
				default: wd_state_q <= i2ctw_pkg::WD_IDLE;
			endcase
		end
	end

	// ==========================================================
	// SDA output timing for remote accesses. In ACK cycles SCL is held
	// low from the falling edge until SDA has settled, so there the setup
	// is met however fast the far controller runs.
	logic [7:0] out_cnt_q;
	logic       pending_q;
	logic       stretch_q;
	logic       sda_low_q;

	always_ff @(posedge osc_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			out_cnt_q <= 8'h00;
			pending_q <= 1'b0;
			stretch_q <= 1'b0;
			sda_low_q <= 1'b0;
		end else if (!remote_active) begin
			pending_q <= 1'b0;
			stretch_q <= 1'b0;
			sda_low_q <= 1'b0;
		end else if (scl_fall) begin
			pending_q <= 1'b1;
			stretch_q <= remote_ack_cycle;
			out_cnt_q <= 8'(i2ctw_pkg::DELAY_BASE_CYC - 1
				+ 32'(l_delay) * i2ctw_pkg::DELAY_STEP_CYC);
		end else if (out_cnt_q != 8'h00) begin
			out_cnt_q <= out_cnt_q - 8'h01;
		end else if (pending_q) begin
			pending_q <= 1'b0;
			sda_low_q <= ~remote_sda_val;
			out_cnt_q <= 8'(i2ctw_pkg::SETUP_BASE_CYC - 1
				+ 32'(l_setup) * i2ctw_pkg::SETUP_STEP_CYC);
		end else begin
			stretch_q <= 1'b0;
		end
	end

	assign scl_o  = 1'b0;
	assign sda_o  = 1'b0;
	assign scl_oe = gen_low_q | stretch_q;
	assign sda_oe = sda_low_q;

endmodule
